// >>> hw/npb_mem.sv
// Small page buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module npb_mem #(
	parameter int W = 16,
	parameter int D = 64,
	localparam int AW = $clog2(D)
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [W-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [W-1:0] rdata_o
);
	logic [W-1:0] mem [D];

	// Write port; contents need no reset, validity is tracked outside
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Registered read, one cycle after the address
	always_ff @(posedge clk_i) begin
		rdata_o <= mem[raddr_i];
	end
endmodule
`default_nettype wire

// >>> hw/npb_programmer.sv
// Flash and EEPROM page buffers with their programming sequencer
`timescale 1ns/1ps
`default_nettype none
`include "npb_defs.svh"
module npb_programmer #(
	parameter int FL_WORDS = `NPB_FL_PAGE_WORDS,
	parameter int EE_BYTES = `NPB_EE_PAGE_BYTES
) (
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire npb_pkg::npb_cmd_s CMD_I,
	input wire logic CMD_VALID_I,
	output logic CMD_READY_O,
	output logic CMD_REFUSED_O,
	output logic DONE_O,
	output logic BUSY_O,
	output logic ABORT_O,
	input wire npb_pkg::npb_lock_s LOCK_I,
	input wire logic PROG_DEBUG_PORT_EN_I,
	input wire logic POWER_ON_THRESHOLD_LOW_I,
	input wire logic BROWNOUT_MONITOR_LOW_I,
	output logic POWER_ON_THRESHOLD_EN_O,
	output logic BROWNOUT_MONITOR_FORCE_O,
	output npb_pkg::npb_arr_s ARRAY_O,
	output npb_pkg::npb_crc_s CRC_RD_O
);
	import npb_pkg::*;

	localparam int FAW = $clog2(FL_WORDS);
	localparam int EAW = $clog2(EE_BYTES);
	localparam int IW = (FAW > EAW) ? FAW : EAW;
	localparam int AW = `NPB_ADDR_W;

	typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_SCAN_RD, ST_SCAN_WR, ST_WAIT, ST_CRC} npb_st_e;

	npb_st_e state;
	logic [IW-1:0] idx;
	npb_aop_e cur_op;
	logic is_eep, is_sig, is_chip, do_write, clr_fl, clr_ee;
	logic [AW-1:0] base;
	logic [IW-1:0] ld_idx;
	logic [`NPB_FL_WORD_W-1:0] ld_data;
	logic ld_eep;
	logic [`NPB_WAIT_W-1:0] wait_cnt;
	logic [AW-1:0] crc_addr, crc_left;
	logic [FL_WORDS-1:0] fl_valid;
	logic [EE_BYTES-1:0] ee_tag;
	logic [1:0] port_s, pot_s, bod_s;
	logic [`NPB_FL_WORD_W-1:0] fl_rdata;
	logic [`NPB_EE_BYTE_W-1:0] ee_rdata;
	logic go, blocked, programming, low_supply, abort, last, emit, fin;
	logic fl_rd_blk, fl_wr_blk, ee_wr_blk;
	logic [AW-1:0] crc_len;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Supply monitors and port enable come from other logic, two flops each
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			port_s <= 2'h0;
			pot_s <= 2'h0;
			bod_s <= 2'h0;
		end else begin
			port_s <= {port_s[0], PROG_DEBUG_PORT_EN_I};
			pot_s <= {pot_s[0], POWER_ON_THRESHOLD_LOW_I};
			bod_s <= {bod_s[0], BROWNOUT_MONITOR_LOW_I};
		end
	end

	// ----------------------------------------
	// Command acceptance and protection
	// ----------------------------------------
	// Lock view chosen by the requesting source
	assign fl_rd_blk = CMD_I.src_ext ? LOCK_I.ext_fl_rd : LOCK_I.app_fl_rd;
	assign fl_wr_blk = CMD_I.src_ext ? LOCK_I.ext_fl_wr : LOCK_I.app_fl_wr;
	assign ee_wr_blk = CMD_I.src_ext ? LOCK_I.ext_ee_wr : LOCK_I.app_ee_wr;

	always_comb begin
		case (CMD_I.code)
			CMD_FL_LOAD, CMD_FL_CLEAR, CMD_FL_ERASE, CMD_FL_WRITE, CMD_FL_ERASE_WRITE,
			CMD_SIG_WRITE: blocked = fl_wr_blk;
			CMD_EE_LOAD, CMD_EE_CLEAR, CMD_EE_ERASE, CMD_EE_WRITE,
			CMD_EE_ERASE_WRITE: blocked = ee_wr_blk;
			CMD_CRC_RANGE: blocked = fl_rd_blk;
			default: blocked = 1'b0;
		endcase
	end

	// Only idle takes commands, so loads and clears never meet programming
	assign CMD_READY_O = (state == ST_IDLE);
	assign BUSY_O = (state != ST_IDLE);
	assign go = CMD_VALID_I && CMD_READY_O && !blocked;
	assign programming = (state == ST_SCAN_RD) || (state == ST_SCAN_WR) || (state == ST_WAIT);
	assign low_supply = pot_s[1] || bod_s[1];
	assign abort = programming && low_supply;
	assign last = (cur_op == AOP_ERASE && !is_eep) ||
		(is_eep ? (idx == IW'(EE_BYTES - 1)) : (idx == IW'(FL_WORDS - 1)));
	assign fin = (state == ST_WAIT) && (wait_cnt == '0) && !abort &&
		!(cur_op == AOP_ERASE && do_write);
	// Only tagged EEPROM bytes reach the array
	assign emit = (state == ST_SCAN_WR) && !abort && (!is_eep || ee_tag[idx[EAW-1:0]]);
	assign crc_len = CMD_I.end_addr - CMD_I.addr + AW'(1);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			state <= ST_IDLE;
			idx <= '0;
			cur_op <= AOP_WRITE;
			{is_eep, is_sig, is_chip, do_write, clr_fl, clr_ee} <= 6'h00;
			base <= '0;
			ld_idx <= '0;
			ld_data <= '0;
			ld_eep <= 1'b0;
			wait_cnt <= '0;
			crc_addr <= '0;
			crc_left <= '0;
		end else if (abort) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (go) begin
						idx <= '0;
						is_eep <= CMD_I.code inside {CMD_EE_ERASE, CMD_EE_WRITE, CMD_EE_ERASE_WRITE};
						is_sig <= (CMD_I.code == CMD_SIG_WRITE);
						is_chip <= (CMD_I.code == CMD_CHIP_ERASE);
						do_write <= CMD_I.code inside {CMD_FL_WRITE, CMD_FL_ERASE_WRITE,
							CMD_SIG_WRITE, CMD_EE_WRITE, CMD_EE_ERASE_WRITE};
						clr_fl <= CMD_I.code inside {CMD_FL_WRITE, CMD_FL_ERASE_WRITE,
							CMD_SIG_WRITE, CMD_LOCK_WRITE};
						clr_ee <= CMD_I.code inside {CMD_EE_WRITE, CMD_EE_ERASE_WRITE,
							CMD_LOCK_WRITE, CMD_FUSE_WRITE};
						// Atomic commands start with the erase pass
						cur_op <= (CMD_I.code inside {CMD_FL_ERASE, CMD_FL_ERASE_WRITE,
							CMD_EE_ERASE, CMD_EE_ERASE_WRITE}) ? AOP_ERASE : AOP_WRITE;
						base <= (CMD_I.code inside {CMD_EE_ERASE, CMD_EE_WRITE,
							CMD_EE_ERASE_WRITE}) ? (CMD_I.addr & ~AW'(EE_BYTES - 1)) :
							(CMD_I.addr & ~AW'(2 * FL_WORDS - 1));
						ld_eep <= (CMD_I.code == CMD_EE_LOAD);
						ld_idx <= (CMD_I.code == CMD_EE_LOAD) ? IW'(CMD_I.addr[EAW-1:0]) :
							IW'(CMD_I.addr[FAW:1]);
						ld_data <= CMD_I.data;
						crc_addr <= CMD_I.addr;
						crc_left <= crc_len + AW'(crc_len[0]);
						wait_cnt <= `NPB_WAIT_W'(`NPB_OP_CYCLES);
						case (CMD_I.code)
							CMD_FL_LOAD, CMD_EE_LOAD: state <= ST_LOAD;
							CMD_FL_ERASE, CMD_FL_WRITE, CMD_FL_ERASE_WRITE, CMD_SIG_WRITE,
							CMD_EE_ERASE, CMD_EE_WRITE, CMD_EE_ERASE_WRITE: state <= ST_SCAN_RD;
							CMD_LOCK_WRITE, CMD_FUSE_WRITE, CMD_CHIP_ERASE: state <= ST_WAIT;
							CMD_CRC_RANGE: state <= ST_CRC;
							default: state <= ST_IDLE;
						endcase
					end
				end
				ST_LOAD: state <= ST_IDLE;
				ST_SCAN_RD: state <= ST_SCAN_WR;
				ST_SCAN_WR: begin
					if (last) begin
						state <= ST_WAIT;
						wait_cnt <= `NPB_WAIT_W'(`NPB_OP_CYCLES);
					end else begin
						idx <= idx + IW'(1);
						state <= ST_SCAN_RD;
					end
				end
				ST_WAIT: begin
					if (wait_cnt != '0) begin
						wait_cnt <= wait_cnt - `NPB_WAIT_W'(1);
					end else if (cur_op == AOP_ERASE && do_write) begin
						cur_op <= AOP_WRITE; // second pass of an atomic command
						idx <= '0;
						state <= ST_SCAN_RD;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_CRC: begin
					crc_addr <= crc_addr + AW'(1);
					crc_left <= crc_left - AW'(1);
					if (crc_left <= AW'(1)) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Page buffers
	// ----------------------------------------
	// Load reads the old entry at accept, writes the AND one cycle later
	npb_mem #(.W(`NPB_FL_WORD_W), .D(FL_WORDS)) u_fl_buf (
		.clk_i(CORE_CLK_I),
		.we_i((state == ST_LOAD) && !ld_eep),
		.waddr_i(ld_idx[FAW-1:0]),
		.wdata_i((fl_valid[ld_idx[FAW-1:0]] ? fl_rdata : `NPB_ERASED_WORD) & ld_data),
		.raddr_i((state == ST_IDLE) ? CMD_I.addr[FAW:1] : idx[FAW-1:0]),
		.rdata_o(fl_rdata)
	);

	npb_mem #(.W(`NPB_EE_BYTE_W), .D(EE_BYTES)) u_ee_buf (
		.clk_i(CORE_CLK_I),
		.we_i((state == ST_LOAD) && ld_eep),
		.waddr_i(ld_idx[EAW-1:0]),
		.wdata_i((ee_tag[ld_idx[EAW-1:0]] ? ee_rdata : `NPB_ERASED_BYTE) &
			ld_data[`NPB_EE_BYTE_W-1:0]),
		.raddr_i((state == ST_IDLE) ? CMD_I.addr[EAW-1:0] : idx[EAW-1:0]),
		.rdata_o(ee_rdata)
	);

	// Flash entry validity; a cleared entry reads back as all ones
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I || fin && clr_fl || go && CMD_I.code == CMD_FL_CLEAR) begin
			fl_valid <= '0;
		end else if (state == ST_LOAD && !ld_eep) begin
			fl_valid <= fl_valid | (FL_WORDS'(1) << ld_idx[FAW-1:0]);
		end
	end

	// EEPROM tags; contents are only meaningful where tagged, so clearing tags clears the buffer
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I || fin && clr_ee || go && CMD_I.code == CMD_EE_CLEAR) begin
			ee_tag <= '0;
		end else if (state == ST_LOAD && ld_eep) begin
			ee_tag <= ee_tag | (EE_BYTES'(1) << ld_idx[EAW-1:0]);
		end
	end

	// ----------------------------------------
	// Array, CRC and supply outputs
	// ----------------------------------------
	// Array strobes: page scans and single-shot lock, fuse and chip erase
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			ARRAY_O <= '0;
		end else begin
			ARRAY_O.valid <= emit || go && CMD_I.code inside {CMD_LOCK_WRITE, CMD_FUSE_WRITE,
				CMD_CHIP_ERASE};
			if (state == ST_IDLE) begin
				ARRAY_O.op <= (CMD_I.code == CMD_LOCK_WRITE) ? AOP_LOCK :
					(CMD_I.code == CMD_FUSE_WRITE) ? AOP_FUSE : AOP_CHIP_ERASE;
				ARRAY_O.tgt <= TGT_FLASH;
				ARRAY_O.addr <= CMD_I.addr;
				ARRAY_O.data <= CMD_I.data;
			end else begin
				ARRAY_O.op <= cur_op;
				ARRAY_O.tgt <= is_eep ? TGT_EEPROM : (is_sig ? TGT_SIGROW : TGT_FLASH);
				ARRAY_O.addr <= base + (is_eep ? AW'(idx) : AW'({idx, 1'b0}));
				// Erase ignores buffer data; unloaded flash words go out as all ones
				ARRAY_O.data <= (cur_op == AOP_ERASE) ? `NPB_ERASED_WORD :
					is_eep ? {8'h00, ee_rdata} :
					(fl_valid[idx[FAW-1:0]] ? fl_rdata : `NPB_ERASED_WORD);
			end
		end
	end

	// CRC byte reads, padded to an even count
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			CRC_RD_O <= '0;
		end else begin
			CRC_RD_O.valid <= (state == ST_CRC);
			CRC_RD_O.addr <= crc_addr;
		end
	end

	// Status pulses and the sticky abort flag
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			CMD_REFUSED_O <= 1'b0;
			DONE_O <= 1'b0;
			ABORT_O <= 1'b0;
		end else begin
			CMD_REFUSED_O <= CMD_VALID_I && CMD_READY_O && blocked;
			DONE_O <= fin || (state == ST_LOAD) || (state == ST_CRC && crc_left <= AW'(1)) ||
				go && CMD_I.code inside {CMD_FL_CLEAR, CMD_EE_CLEAR, CMD_NOP};
			if (abort) begin
				ABORT_O <= 1'b1;
			end else if (go) begin
				ABORT_O <= 1'b0;
			end
		end
	end

	// Supply monitors; raised at accept so the first array strobe is already guarded
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I) begin
			POWER_ON_THRESHOLD_EN_O <= 1'b0;
			BROWNOUT_MONITOR_FORCE_O <= 1'b0;
		end else begin
			POWER_ON_THRESHOLD_EN_O <= programming || go && !(CMD_I.code inside {CMD_NOP,
				CMD_FL_LOAD, CMD_FL_CLEAR, CMD_EE_LOAD, CMD_EE_CLEAR, CMD_CRC_RANGE});
			BROWNOUT_MONITOR_FORCE_O <= port_s[1] || (programming && is_chip) ||
				go && (CMD_I.code == CMD_CHIP_ERASE);
		end
	end
endmodule
`default_nettype wire

// >>> pkg/npb_defs.svh
// Constants of the nonvolatile page buffer programmer
`ifndef NPB_DEFS_SVH
`define NPB_DEFS_SVH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define NPB_FL_PAGE_WORDS 64
`define NPB_EE_PAGE_BYTES 32
`define NPB_ADDR_W 24
`define NPB_FL_WORD_W 16
`define NPB_EE_BYTE_W 8
// ----------------------------------------
// Values and timing
// ----------------------------------------
`define NPB_ERASED_WORD 16'hFFFF
`define NPB_ERASED_BYTE 8'hFF
`define NPB_CLK_MHZ 20
`define NPB_T_OP_US 4
`define NPB_OP_CYCLES ((`NPB_T_OP_US) * (`NPB_CLK_MHZ))
`define NPB_WAIT_W 16
`endif

// >>> pkg/npb_pkg.sv
// Types shared by the page buffer programmer and its users
`include "npb_defs.svh"
package npb_pkg;
	// ----------------------------------------
	// Commands, array operations, targets
	// ----------------------------------------
	typedef enum logic [3:0] {
		CMD_NOP, CMD_FL_LOAD, CMD_FL_CLEAR, CMD_FL_ERASE, CMD_FL_WRITE, CMD_FL_ERASE_WRITE,
		CMD_SIG_WRITE, CMD_EE_LOAD, CMD_EE_CLEAR, CMD_EE_ERASE, CMD_EE_WRITE,
		CMD_EE_ERASE_WRITE, CMD_LOCK_WRITE, CMD_FUSE_WRITE, CMD_CHIP_ERASE, CMD_CRC_RANGE
	} npb_cmd_e;
	typedef enum logic [2:0] {
		AOP_ERASE, AOP_WRITE, AOP_CHIP_ERASE, AOP_LOCK, AOP_FUSE
	} npb_aop_e;
	typedef enum logic [1:0] {TGT_FLASH, TGT_EEPROM, TGT_SIGROW} npb_tgt_e;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		npb_cmd_e code;
		logic src_ext; // 1: external programmer, 0: application software
		logic [`NPB_ADDR_W-1:0] addr; // byte address, CRC start
		logic [`NPB_ADDR_W-1:0] end_addr; // CRC range end, inclusive
		logic [`NPB_FL_WORD_W-1:0] data;
	} npb_cmd_s;
	typedef struct packed {
		logic ext_fl_rd;
		logic ext_fl_wr;
		logic ext_ee_wr;
		logic app_fl_rd;
		logic app_fl_wr;
		logic app_ee_wr;
	} npb_lock_s;
	typedef struct packed {
		logic valid;
		npb_aop_e op;
		npb_tgt_e tgt;
		logic [`NPB_ADDR_W-1:0] addr;
		logic [`NPB_FL_WORD_W-1:0] data;
	} npb_arr_s;
	typedef struct packed {
		logic valid;
		logic [`NPB_ADDR_W-1:0] addr;
	} npb_crc_s;
endpackage

// >>> verification/npb_host_model.sv
// Command source standing in for software or an external programmer
`timescale 1ns/1ps
`default_nettype none
module npb_host_model (
	input wire logic clk_i,
	input wire logic ready_i,
	input wire logic done_i,
	input wire logic refused_i,
	input wire logic abort_i,
	output npb_pkg::npb_cmd_s cmd_o,
	output logic valid_o
);
	import npb_pkg::*;
	// 1 done, 2 refused, 3 aborted, 0 no answer
	logic [1:0] outcome;
	initial begin
		cmd_o = '0;
		valid_o = 1'b0;
		outcome = 2'h0;
	end
	// Request held until ready is seen at an edge, then released
	task automatic send(input npb_cmd_e code, input logic ext, input logic [23:0] addr,
		input logic [23:0] end_addr, input logic [15:0] data);
		int n;
		@(posedge clk_i);
		cmd_o <= '{code, ext, addr, end_addr, data};
		valid_o <= 1'b1;
		do @(posedge clk_i); while (ready_i !== 1'b1);
		valid_o <= 1'b0;
		cmd_o <= ~cmd_o; // Released fields turn over so no stale value lingers
		outcome = 2'h0;
		for (n = 0; n < 600 && outcome == 2'h0; n++) begin
			@(posedge clk_i);
			if (done_i === 1'b1) outcome = 2'h1;
			else if (refused_i === 1'b1) outcome = 2'h2;
			else if (abort_i === 1'b1) outcome = 2'h3;
		end
		@(posedge clk_i); // Lets monitors of the last edge settle
	endtask
endmodule
`default_nettype wire

// >>> verification/npb_prog_chk.sv
// Port assertions for the page buffer programmer
`timescale 1ns/1ps
`default_nettype none
module npb_prog_chk #(
	parameter int FL_WORDS = 64,
	parameter int EE_BYTES = 32
) (
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire npb_pkg::npb_cmd_s CMD_I,
	input wire logic CMD_VALID_I,
	input wire logic CMD_READY_O,
	input wire logic CMD_REFUSED_O,
	input wire logic DONE_O,
	input wire logic BUSY_O,
	input wire logic ABORT_O,
	input wire logic PROG_DEBUG_PORT_EN_I,
	input wire logic POWER_ON_THRESHOLD_LOW_I,
	input wire logic BROWNOUT_MONITOR_LOW_I,
	input wire logic POWER_ON_THRESHOLD_EN_O,
	input wire logic BROWNOUT_MONITOR_FORCE_O,
	input wire npb_pkg::npb_arr_s ARRAY_O,
	input wire npb_pkg::npb_crc_s CRC_RD_O
);
	import npb_pkg::*;
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	// ----------------------------------------
	// Helper counts and sequences
	// ----------------------------------------
	// CRC reads of the running command; cleared at completion
	logic [7:0] crc_n;
	always_ff @(posedge CORE_CLK_I) begin
		if (!RESETN_I || DONE_O) crc_n <= 8'h00;
		else if (CRC_RD_O.valid) crc_n <= crc_n + 8'h01;
	end
	sequence s_load_taken;
		CMD_VALID_I && CMD_READY_O && (CMD_I.code inside {CMD_FL_LOAD, CMD_EE_LOAD});
	endsequence
	sequence s_low_prog;
		(POWER_ON_THRESHOLD_LOW_I || BROWNOUT_MONITOR_LOW_I) && POWER_ON_THRESHOLD_EN_O;
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_busy_blocks: assert property (BUSY_O == !CMD_READY_O)
		else $error("ready and busy disagree");
	a_busy_ends: assert property ($fell(BUSY_O) |-> DONE_O || ABORT_O)
		else $error("busy dropped without completion or abort");
	a_load_latency: assert property (s_load_taken |-> ##1 CMD_REFUSED_O or ##2 DONE_O)
		else $error("load not answered in two cycles");
	a_refuse_quiet: assert property (CMD_REFUSED_O |-> !BUSY_O && !DONE_O)
		else $error("refused command changed state");
	a_array_guarded: assert property (ARRAY_O.valid |-> POWER_ON_THRESHOLD_EN_O && BUSY_O)
		else $error("array access without supply detector");
	a_erase_ones: assert property (ARRAY_O.valid && ARRAY_O.op == AOP_ERASE
		|-> ARRAY_O.data == 16'hFFFF)
		else $error("erase carries data");
	a_flash_aligned: assert property (ARRAY_O.valid && ARRAY_O.tgt == TGT_FLASH
		|-> ARRAY_O.addr[0] == 1'b0)
		else $error("flash access not word aligned");
	a_low_aborts: assert property (s_low_prog [*3] |-> ##[0:2] ABORT_O)
		else $error("low supply did not abort");
	a_abort_idle: assert property ($rose(ABORT_O) |-> !DONE_O ##1 !BUSY_O)
		else $error("abort did not stop the sequence");
	a_port_forces: assert property (PROG_DEBUG_PORT_EN_I [*4] |-> BROWNOUT_MONITOR_FORCE_O)
		else $error("brownout monitor not forced");
	a_crc_even: assert property (DONE_O && CRC_RD_O.valid |-> crc_n[0])
		else $error("odd number of CRC reads");
endmodule
`default_nettype wire

// >>> verification/nvm_page_buffer_programmer_test.sv
// Self-checking bench for the page buffer programmer
`timescale 1ns/1ps
`default_nettype none
module nvm_page_buffer_programmer_test;
	import npb_pkg::*;
	logic clk, rst_n, cmd_valid, ready, refused, done, busy, abort;
	logic port_en, pot_low, bod_low, pot_en, bod_force;
	npb_cmd_s cmd;
	npb_lock_s lock;
	npb_arr_s arr;
	npb_crc_s crc;
	npb_arr_s arr_q[$];
	logic [23:0] crc_q[$];
	int failures, n_compared;
	npb_programmer dut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .CMD_I(cmd),
		.CMD_VALID_I(cmd_valid), .CMD_READY_O(ready), .CMD_REFUSED_O(refused),
		.DONE_O(done), .BUSY_O(busy), .ABORT_O(abort), .LOCK_I(lock),
		.PROG_DEBUG_PORT_EN_I(port_en), .POWER_ON_THRESHOLD_LOW_I(pot_low),
		.BROWNOUT_MONITOR_LOW_I(bod_low), .POWER_ON_THRESHOLD_EN_O(pot_en),
		.BROWNOUT_MONITOR_FORCE_O(bod_force), .ARRAY_O(arr), .CRC_RD_O(crc));
	npb_host_model host (.clk_i(clk), .ready_i(ready), .done_i(done), .refused_i(refused),
		.abort_i(abort), .cmd_o(cmd), .valid_o(cmd_valid));
	// ----------------------------------------
	// Clock, monitors, helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Array and CRC pulses logged for later comparison
	always @(posedge clk) begin
		if (arr.valid === 1'b1) arr_q.push_back(arr);
		if (crc.valid === 1'b1) crc_q.push_back(crc.addr);
	end
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic op(input npb_cmd_e c, input logic [23:0] a, input logic [15:0] d,
		input logic [1:0] want);
		host.send(c, 1'b0, a, 24'h00_0000, d);
		check(host.outcome, want);
	endtask
	task automatic print_verdict;
		if (failures == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_lock;
		@(posedge clk);
		lock <= 6'h02;
		op(CMD_FL_LOAD, 24'h00_0000, 16'h0000, 2'h2);
		host.send(CMD_FL_LOAD, 1'b1, 24'h00_0000, 24'h00_0000, 16'h0000);
		check(host.outcome, 2'h1);
		lock <= 6'h04;
		op(CMD_CRC_RANGE, 24'h00_0000, 16'h0000, 2'h2);
		lock <= 6'h00;
	endtask
	task automatic t_flash_split;
		op(CMD_FL_CLEAR, 24'h00_0100, 16'h0000, 2'h1);
		op(CMD_FL_LOAD, 24'h00_0104, 16'h0F0F, 2'h1);
		op(CMD_FL_LOAD, 24'h00_0105, 16'h3C3C, 2'h1);
		arr_q.delete();
		op(CMD_FL_ERASE, 24'h00_0100, 16'h0000, 2'h1);
		check(arr_q.size(), 1);
		check({arr_q[0].op, arr_q[0].addr}, {AOP_ERASE, 24'h00_0100});
		arr_q.delete();
		op(CMD_FL_WRITE, 24'h00_0100, 16'h0000, 2'h1);
		check(arr_q.size(), 64);
		foreach (arr_q[i]) check({arr_q[i].addr, arr_q[i].data},
			{24'h00_0100 + 24'(i * 2), i == 2 ? 16'h0C0C : 16'hFFFF});
		op(CMD_FL_ERASE, 24'h00_0100, 16'h0000, 2'h1);
		op(CMD_FL_LOAD, 24'h00_0100, 16'h1234, 2'h1);
		arr_q.delete();
		op(CMD_FL_WRITE, 24'h00_0100, 16'h0000, 2'h1);
		check(arr_q[2].data, 16'hFFFF);
		check(arr_q[0].data, 16'h1234);
	endtask
	task automatic t_eeprom;
		op(CMD_EE_CLEAR, 24'h00_0040, 16'h0000, 2'h1);
		op(CMD_EE_LOAD, 24'h00_0043, 16'h00A5, 2'h1);
		op(CMD_EE_LOAD, 24'h00_0047, 16'h005A, 2'h1);
		op(CMD_EE_LOAD, 24'h00_0047, 16'h000F, 2'h1);
		arr_q.delete();
		op(CMD_EE_ERASE, 24'h00_0040, 16'h0000, 2'h1);
		check(arr_q.size(), 2);
		check({arr_q[0].addr, arr_q[1].addr}, {24'h00_0043, 24'h00_0047});
		arr_q.delete();
		op(CMD_EE_WRITE, 24'h00_0040, 16'h0000, 2'h1);
		check(arr_q.size(), 2);
		check({arr_q[0].data[7:0], arr_q[1].data[7:0], arr_q[1].tgt},
			{8'hA5, 8'h0A, TGT_EEPROM});
		op(CMD_EE_LOAD, 24'h00_0041, 16'h0000, 2'h1);
		arr_q.delete();
		op(CMD_EE_ERASE_WRITE, 24'h00_0040, 16'h0000, 2'h1);
		check(arr_q.size(), 2);
	endtask
	task automatic t_crc;
		crc_q.delete();
		host.send(CMD_CRC_RANGE, 1'b0, 24'h00_000A, 24'h00_000E, 16'h0000);
		check(host.outcome, 2'h1);
		check(crc_q.size(), 6);
		foreach (crc_q[i]) check(crc_q[i], 24'h00_000A + 24'(i));
	endtask
	task automatic t_auto_clear;
		npb_cmd_e codes[3] = '{CMD_SIG_WRITE, CMD_LOCK_WRITE, CMD_FUSE_WRITE};
		for (int k = 0; k < 3; k++) begin
			op(CMD_FL_LOAD, 24'h00_0300, 16'h0000, 2'h1);
			op(CMD_EE_LOAD, 24'h00_0060, 16'h0000, 2'h1);
			op(codes[k], 24'h00_0000, 16'h0000, 2'h1);
			op(CMD_EE_LOAD, 24'h00_0065, 16'h0011, 2'h1);
			arr_q.delete();
			op(CMD_FL_ERASE_WRITE, 24'h00_0300, 16'h0000, 2'h1);
			op(CMD_EE_ERASE_WRITE, 24'h00_0060, 16'h0000, 2'h1);
			check(arr_q[1].data, k == 2 ? 16'h0000 : 16'hFFFF);
			check(arr_q.size(), k == 0 ? 69 : 67);
		end
	endtask
	task automatic t_abort;
		for (int k = 0; k < 2; k++) begin
			op(CMD_FL_LOAD, 24'h00_0200, 16'h5555, 2'h1);
			fork
				op(CMD_FL_ERASE_WRITE, 24'h00_0200, 16'h0000, 2'h3);
				begin
					repeat (40) @(posedge clk);
					if (k == 0) pot_low <= 1'b1;
					else bod_low <= 1'b1;
				end
			join
			pot_low <= 1'b0;
			bod_low <= 1'b0;
			repeat (4) @(posedge clk);
			arr_q.delete();
			op(CMD_FL_ERASE_WRITE, 24'h00_0200, 16'h0000, 2'h1);
			check({abort, arr_q[1].data}, {1'b0, 16'h5555});
		end
	endtask
	task automatic t_force;
		port_en <= 1'b1;
		repeat (5) @(posedge clk);
		check(bod_force, 1'b1);
		port_en <= 1'b0;
		fork
			op(CMD_CHIP_ERASE, 24'h00_0000, 16'h0000, 2'h1);
			begin
				repeat (20) @(posedge clk);
				check({bod_force, pot_en, busy}, 3'h7);
			end
		join
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		lock = '0;
		port_en = 1'b0;
		pot_low = 1'b0;
		bod_low = 1'b0;
		failures = 0;
		n_compared = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_lock();
		t_flash_split();
		t_eeprom();
		t_crc();
		t_auto_clear();
		t_abort();
		t_force();
		print_verdict();
	end
	// Cut off a hang well past the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		print_verdict();
	end
endmodule
bind npb_programmer npb_prog_chk #(.FL_WORDS(FL_WORDS), .EE_BYTES(EE_BYTES)) chk (
	.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .CMD_I(CMD_I), .CMD_VALID_I(CMD_VALID_I),
	.CMD_READY_O(CMD_READY_O), .CMD_REFUSED_O(CMD_REFUSED_O), .DONE_O(DONE_O),
	.BUSY_O(BUSY_O), .ABORT_O(ABORT_O), .PROG_DEBUG_PORT_EN_I(PROG_DEBUG_PORT_EN_I),
	.POWER_ON_THRESHOLD_LOW_I(POWER_ON_THRESHOLD_LOW_I),
	.BROWNOUT_MONITOR_LOW_I(BROWNOUT_MONITOR_LOW_I),
	.POWER_ON_THRESHOLD_EN_O(POWER_ON_THRESHOLD_EN_O),
	.BROWNOUT_MONITOR_FORCE_O(BROWNOUT_MONITOR_FORCE_O), .ARRAY_O(ARRAY_O),
	.CRC_RD_O(CRC_RD_O));
`default_nettype wire
